// ==== general_maskable_request_pkg.sv ====
// Package for the interrupt and serial I/O block of an 8-bit processor core.
// Assumes nothing beyond a single clock domain.
package general_maskable_request_pkg;
    localparam int NUM_SRC = 5;
    // Restart vectors
    localparam logic [7:0] VEC_NMI = 8'h24;
    localparam logic [7:0] VEC_EDGE = 8'h3C;
    localparam logic [7:0] VEC_MID = 8'h34;
    localparam logic [7:0] VEC_LOW = 8'h2C;
    localparam logic [7:0] VEC_NONE = 8'h00;
    // Read-mask result bit positions
    localparam int RD_LOW_MASK = 0;
    localparam int RD_MID_MASK = 1;
    localparam int RD_EDGE_MASK = 2;
    localparam int RD_IE = 3;
    localparam int RD_LOW_PEND = 4;
    localparam int RD_MID_PEND = 5;
    localparam int RD_EDGE_PEND = 6;
    localparam int RD_SERIAL = 7;
    // Set-mask operand bit positions
    localparam int WR_LOW_MASK = 0;
    localparam int WR_MID_MASK = 1;
    localparam int WR_EDGE_MASK = 2;
    localparam int WR_MASK_EN = 3;
    localparam int WR_EDGE_CLR = 4;
    localparam int WR_SER_EN = 6;
    localparam int WR_SERIAL = 7;
    // Reset value and synchroniser depth
    localparam logic [2:0] MASK_RST = 3'h7;
    localparam int SYNC_STAGES = 2;
    // Which source won arbitration
    typedef enum logic [2:0] {
        SRC_NONE, SRC_NMI, SRC_EDGE, SRC_MID, SRC_LOW, SRC_GEN
    } src_type;
endpackage : general_maskable_request_pkg

// ==== general_maskable_request_sync.sv ====
// Two-flop synchroniser for a bus of asynchronous request inputs.
// Assumes the clock enable gates all state in the system.
`timescale 1ns/1ns
module general_maskable_request_sync #(
    parameter int WIDTH = 5
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import general_maskable_request_pkg::*;

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] sync_nxt;

    always_comb begin
        meta_nxt = meta_r;
        sync_nxt = sync_r;
        if (clk_en) begin
            meta_nxt = async_in;
            sync_nxt = meta_r;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;
endmodule : general_maskable_request_sync

// ==== general_maskable_request_ctrl.sv ====
// Interrupt and one-bit serial I/O logic of an 8-bit processor core.
// Assumes the core pulses instr_boundary, the read/set mask strobes and
// the enable/disable strobes for one cycle each, and follows a granted
// restart by pushing the PC and branching to restart_vector.
//
// Contract
// - Priority: nonmask, edge, mid, low, general
// - Each restart input has its own mask
// - Maskable restart needs enable and clear mask
// - Nonmaskable ignores enable and masks
// - Low and mid restarts are level sensitive
// - Edge restart latched, cleared on service
// - Edge latch cleared by set-mask with bit 4 set, reset
// - Edge latch sets even when masked
// - Only pending requests compete; nesting allowed
// - Nonmaskable rearms only once its line is seen low
// - Service clears global enable until enable op
// - First read after nonmaskable shows saved enable
// - Read after maskable service shows disabled
// - All requests synchronised to clock
// - Fixed restart vectors 24H 3CH 34H 2CH
// - Read-mask puts serial in at bit 7
// - Reset clears global enable
`timescale 1ns/1ns
module general_maskable_request_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Interrupt request pins
    input wire logic nmi_request,
    input wire logic edge_restart,
    input wire logic mid_restart,
    input wire logic low_restart,
    input wire logic general_maskable_request,
    // Serial pins
    input wire logic serial_in_line,
    output logic serial_out_line,
    // Core instruction strobes
    input wire logic instr_boundary,
    input wire logic read_interrupt_mask_op,
    input wire logic set_interrupt_mask_op,
    input wire logic [7:0] set_mask_data,
    input wire logic enable_interrupts_op,
    input wire logic disable_interrupts_op,
    // Core restart request, read-mask result and enable state
    output logic general_maskable_request_grant,
    output general_maskable_request_pkg::src_type grant_source,
    output logic [7:0] restart_vector,
    output logic interrupt_acknowledge_strobe,
    output logic [7:0] read_mask_data,
    output logic int_enable
);
    import general_maskable_request_pkg::*;

    logic [NUM_SRC-1:0] raw_req;
    logic [NUM_SRC-1:0] sync_req;
    logic nmi_s;
    logic edge_s;
    logic mid_s;
    logic low_s;
    logic gen_s;

    logic ie_r, ie_nxt;
    logic ie_saved_r, ie_saved_nxt;
    logic nmi_read_pend_r, nmi_read_pend_nxt;
    logic [2:0] mask_r, mask_nxt;
    logic edge_prev_r, edge_prev_nxt;
    logic edge_latch_r, edge_latch_nxt;
    logic nmi_armed_r, nmi_armed_nxt;
    logic sod_r, sod_nxt;
    logic [7:0] rd_r, rd_nxt;
    logic grant_r, grant_nxt;
    logic ack_r, ack_nxt;
    src_type src_r, src_nxt;
    logic [7:0] vec_r, vec_nxt;
    src_type winner;

    // Vector lookup for a given source
    function automatic logic [7:0] vec_of(input src_type s);
        case (s)
            SRC_NMI: vec_of = VEC_NMI;
            SRC_EDGE: vec_of = VEC_EDGE;
            SRC_MID: vec_of = VEC_MID;
            SRC_LOW: vec_of = VEC_LOW;
            default: vec_of = VEC_NONE;
        endcase
    endfunction : vec_of

    assign raw_req = {general_maskable_request, low_restart, mid_restart,
                      edge_restart, nmi_request};
    general_maskable_request_sync #(.WIDTH(NUM_SRC)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .async_in(raw_req),
        .sync_out(sync_req)
    );
    assign nmi_s = sync_req[0];
    assign edge_s = sync_req[1];
    assign mid_s = sync_req[2];
    assign low_s = sync_req[3];
    assign gen_s = sync_req[4];

    // Arbitration among pending requests
    always_comb begin
        winner = SRC_NONE;
        // only an armed, high request is taken
        if (nmi_s && nmi_armed_r) begin
            winner = SRC_NMI;
        // maskable restarts need enable and mask clear
        end else if (ie_r && edge_latch_r && !mask_r[2]) begin
            winner = SRC_EDGE;
        // level sensitive mid and low restarts
        end else if (ie_r && mid_s && !mask_r[1]) begin
            winner = SRC_MID;
        end else if (ie_r && low_s && !mask_r[0]) begin
            winner = SRC_LOW;
        end else if (ie_r && gen_s) begin
            winner = SRC_GEN;
        end
    end

    always_comb begin
        ie_nxt = ie_r;
        ie_saved_nxt = ie_saved_r;
        nmi_read_pend_nxt = nmi_read_pend_r;
        mask_nxt = mask_r;
        edge_prev_nxt = edge_prev_r;
        edge_latch_nxt = edge_latch_r;
        nmi_armed_nxt = nmi_armed_r;
        sod_nxt = sod_r;
        rd_nxt = rd_r;
        grant_nxt = 1'b0;
        ack_nxt = 1'b0;
        src_nxt = src_r;
        vec_nxt = vec_r;
        if (clk_en) begin
            edge_prev_nxt = edge_s;
            // rearm whenever the synchronised line is low
            if (!nmi_s) begin
                nmi_armed_nxt = 1'b1;
            end
            // Enable instructions
            if (enable_interrupts_op) begin
                ie_nxt = 1'b1;
            end else if (disable_interrupts_op) begin
                ie_nxt = 1'b0;
            end
            // Set-mask instruction
            if (set_interrupt_mask_op) begin
                if (set_mask_data[WR_MASK_EN]) begin
                    mask_nxt = set_mask_data[2:0];
                end
                if (set_mask_data[WR_EDGE_CLR]) begin
                    edge_latch_nxt = 1'b0;
                end
                if (set_mask_data[WR_SER_EN]) begin
                    sod_nxt = set_mask_data[WR_SERIAL];
                end
            end
            // nesting allowed once enable is set again
            if (instr_boundary && winner != SRC_NONE) begin
                grant_nxt = 1'b1;
                src_nxt = winner;
                vec_nxt = vec_of(winner);
                ie_nxt = 1'b0;
                ack_nxt = (winner == SRC_GEN);
                if (winner == SRC_NMI) begin
                    // keep prior enable for next read
                    ie_saved_nxt = ie_r;
                    nmi_read_pend_nxt = 1'b1;
                    nmi_armed_nxt = 1'b0;
                end
                if (winner == SRC_EDGE) begin
                    edge_latch_nxt = 1'b0;
                end
            end
            // rising edge sets latch regardless of mask
            if (edge_s && !edge_prev_r) begin
                edge_latch_nxt = 1'b1;
            end
            // Read-mask instruction
            if (read_interrupt_mask_op) begin
                rd_nxt[2:0] = mask_r;
                rd_nxt[RD_IE] = nmi_read_pend_r ? ie_saved_r : ie_r;
                // a new nonmaskable grant wins over the read
                nmi_read_pend_nxt = instr_boundary && winner == SRC_NMI;
                rd_nxt[RD_LOW_PEND] = low_s;
                rd_nxt[RD_MID_PEND] = mid_s;
                rd_nxt[RD_EDGE_PEND] = edge_latch_r;
                rd_nxt[RD_SERIAL] = serial_in_line;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ie_r <= 1'b0;
            ie_saved_r <= 1'b0;
            nmi_read_pend_r <= 1'b0;
            mask_r <= MASK_RST;
            edge_prev_r <= 1'b0;
            edge_latch_r <= 1'b0;
            nmi_armed_r <= 1'b1;
            sod_r <= 1'b0;
            rd_r <= 8'h00;
            grant_r <= 1'b0;
            ack_r <= 1'b0;
            src_r <= SRC_NONE;
            vec_r <= VEC_NONE;
        end else begin
            ie_r <= ie_nxt;
            ie_saved_r <= ie_saved_nxt;
            nmi_read_pend_r <= nmi_read_pend_nxt;
            mask_r <= mask_nxt;
            edge_prev_r <= edge_prev_nxt;
            edge_latch_r <= edge_latch_nxt;
            nmi_armed_r <= nmi_armed_nxt;
            sod_r <= sod_nxt;
            rd_r <= rd_nxt;
            grant_r <= grant_nxt;
            ack_r <= ack_nxt;
            src_r <= src_nxt;
            vec_r <= vec_nxt;
        end
    end

    assign serial_out_line = sod_r;
    assign general_maskable_request_grant = grant_r;
    assign grant_source = src_r;
    assign restart_vector = vec_r;
    assign interrupt_acknowledge_strobe = ack_r;
    assign read_mask_data = rd_r;
    assign int_enable = ie_r;
endmodule : general_maskable_request_ctrl

// ==== general_maskable_request_ctrl_checker.sv ====
// Port checks for the interrupt and serial I/O block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module general_maskable_request_ctrl_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Core strobes
    input wire logic instr_boundary,
    input wire logic read_interrupt_mask_op,
    input wire logic set_interrupt_mask_op,
    input wire logic [7:0] set_mask_data,
    // Serial pins
    input wire logic serial_in_line,
    input wire logic serial_out_line,
    // Results
    input wire logic general_maskable_request_grant,
    input wire general_maskable_request_pkg::src_type grant_source,
    input wire logic [7:0] restart_vector,
    input wire logic interrupt_acknowledge_strobe,
    input wire logic [7:0] read_mask_data,
    input wire logic int_enable
);
    import general_maskable_request_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_won(src_type s);
        general_maskable_request_grant && grant_source == s;
    endsequence
    sequence s_read;
        read_interrupt_mask_op && clk_en;
    endsequence
    AST_VEC_NMI: assert property (
        s_won(SRC_NMI) |-> restart_vector == VEC_NMI) else $error("vector");
    AST_ACK_GEN: assert property (
        interrupt_acknowledge_strobe == (general_maskable_request_grant && grant_source == SRC_GEN))
        else $error("ack strobe");
    AST_GRANT_IE: assert property (
        general_maskable_request_grant |-> !int_enable) else $error("enable kept");
    AST_MASK_IE: assert property (
        general_maskable_request_grant && grant_source != SRC_NMI |-> $past(int_enable))
        else $error("grant while disabled");
    AST_BOUNDARY: assert property (
        general_maskable_request_grant |-> $past(instr_boundary)) else $error("off boundary");
    AST_READ_SER: assert property (
        s_read |=> read_mask_data[RD_SERIAL] == $past(serial_in_line))
        else $error("serial read");
    AST_SER_OUT: assert property (
        set_interrupt_mask_op && clk_en && set_mask_data[WR_SER_EN]
        |=> serial_out_line == $past(set_mask_data[WR_SERIAL]))
        else $error("serial out");
    AST_RESET_IE: assert property (
        $fell(sys_rst) |-> !int_enable) else $error("enable after reset");
endmodule : general_maskable_request_ctrl_checker

bind general_maskable_request_ctrl general_maskable_request_ctrl_checker i_general_maskable_request_ctrl_checker (.clk, .sys_rst,
    .clk_en, .instr_boundary, .read_interrupt_mask_op,
    .set_interrupt_mask_op, .set_mask_data, .serial_in_line,
    .serial_out_line, .general_maskable_request_grant, .grant_source, .restart_vector,
    .interrupt_acknowledge_strobe, .read_mask_data, .int_enable);

// ==== nmi_source.sv ====
// Peripheral that raises the nonmaskable request.
// Assumes the bench pulses fire for one cycle.
`timescale 1ns/1ns
module nmi_source (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Command and answer
    input wire logic fire,
    input wire logic general_maskable_request_grant,
    input wire general_maskable_request_pkg::src_type grant_source,
    // Request line
    output logic nmi_request
);
    import general_maskable_request_pkg::*;
    logic held_r;
    logic held_nxt;
    always_comb begin
        held_nxt = held_r;
        if (fire)
            held_nxt = 1'b1;
        else if (general_maskable_request_grant && grant_source == SRC_NMI)
            held_nxt = 1'b0;
    end
    always_ff @(posedge clk) begin
        held_r <= sys_rst ? 1'b0 : held_nxt;
    end
    assign nmi_request = held_r;
endmodule : nmi_source

// ==== general_maskable_request_ctrl_bench.sv ====
// Self-checking bench for the interrupt and serial I/O block.
// Assumes the request source model and the bound port checker.
`timescale 1ns/1ns
module general_maskable_request_ctrl_bench;
    import general_maskable_request_pkg::*;
    typedef struct packed {
        logic ie;
        logic [2:0] mask;
        logic [4:0] req;
        src_type src;
        logic [7:0] vec;
    } row_type;
    // Requests: nmi, edge, mid, low, general
    row_type rows[8] = '{
        '{1'b1, 3'h0, 5'h0F, SRC_EDGE, VEC_EDGE},
        '{1'b1, 3'h0, 5'h07, SRC_MID, VEC_MID},
        '{1'b1, 3'h0, 5'h03, SRC_LOW, VEC_LOW},
        '{1'b1, 3'h0, 5'h01, SRC_GEN, VEC_NONE},
        '{1'b1, 3'h4, 5'h0F, SRC_MID, VEC_MID},
        '{1'b1, 3'h2, 5'h06, SRC_LOW, VEC_LOW},
        '{1'b0, 3'h0, 5'h0F, SRC_NONE, VEC_NONE},
        '{1'b0, 3'h7, 5'h1F, SRC_NMI, VEC_NMI}};
    logic clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1;
    logic edge_restart = 1'b0, mid_restart = 1'b0, low_restart = 1'b0;
    logic general_maskable_request = 1'b0, serial_in_line = 1'b0;
    logic [5:0] strb = 6'h00;
    logic [7:0] set_mask_data = 8'h00, restart_vector, read_mask_data;
    logic nmi_request, serial_out_line, general_maskable_request_grant, int_enable;
    logic interrupt_acknowledge_strobe;
    src_type grant_source;
    int error_cnt = 0, total_checks = 0;
    wire set_interrupt_mask_op = strb[0];
    wire read_interrupt_mask_op = strb[1];
    wire enable_interrupts_op = strb[2];
    wire disable_interrupts_op = strb[3];
    wire instr_boundary = strb[4];
    wire nmi_fire = strb[5];
    general_maskable_request_ctrl i_general_maskable_request_ctrl (.clk, .sys_rst, .clk_en, .nmi_request,
        .edge_restart, .mid_restart, .low_restart, .general_maskable_request,
        .serial_in_line, .serial_out_line, .instr_boundary,
        .read_interrupt_mask_op, .set_interrupt_mask_op, .set_mask_data,
        .enable_interrupts_op, .disable_interrupts_op, .general_maskable_request_grant,
        .grant_source, .restart_vector, .interrupt_acknowledge_strobe,
        .read_mask_data, .int_enable);
    nmi_source i_nmi_source (.clk, .sys_rst, .fire(nmi_fire), .general_maskable_request_grant,
        .grant_source, .nmi_request);
    initial forever #25 clk = ~clk;
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // One-cycle strobe k with operand d
    task automatic op(input int k, input logic [7:0] d);
        @(posedge clk);
        strb <= 6'h01 << k;
        set_mask_data <= d;
        @(posedge clk);
        strb <= 6'h00;
    endtask : op
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    task automatic do_row(input row_type r);
        src_type src;
        logic [7:0] vec;
        logic ack;
        src = SRC_NONE;
        vec = VEC_NONE;
        ack = 1'b0;
        op(0, {3'h0, 2'h3, r.mask});
        op(r.ie ? 2 : 3, 8'h00);
        {edge_restart, mid_restart, low_restart} <= r.req[3:1];
        general_maskable_request <= r.req[0];
        if (r.req[4]) begin
            op(5, 8'h00);
        end
        tick(4);
        op(4, 8'h00);
        repeat (3) begin
            #1;
            if (general_maskable_request_grant === 1'b1) begin
                src = grant_source;
                vec = restart_vector;
                ack = interrupt_acknowledge_strobe;
            end
            @(posedge clk);
        end
        // edge, mid, low and general requests drop after the grant window, acknowledged or not
        {edge_restart, mid_restart, low_restart} <= 3'h0;
        general_maskable_request <= 1'b0;
        tick(4);
        op(1, 8'h00);
        tick(1);
        chk({5'h0, src}, {5'h0, r.src});
        chk(vec, r.vec);
        chk({7'h0, ack}, {7'h0, r.src == SRC_GEN});
        chk(read_mask_data & 8'h7F, {1'b0, r.req[3] && r.src != SRC_EDGE,
            3'h0, r.mask});
    endtask : do_row
    initial begin
        tick(4);
        sys_rst <= 1'b0;
        tick(3);
        for (int i = 0; i < 8; i++) begin
            do_row(rows[i]);
        end
        op(0, 8'h1F);
        serial_in_line <= 1'b1;
        edge_restart <= 1'b1;
        mid_restart <= 1'b1;
        low_restart <= 1'b1;
        tick(4);
        op(1, 8'h00);
        tick(1);
        chk(read_mask_data & 8'hF0, 8'hF0);
        op(0, 8'h10);
        serial_in_line <= 1'b0;
        op(1, 8'h00);
        tick(1);
        chk(read_mask_data & 8'hC0, 8'h00);
        op(0, 8'hC0);
        tick(1);
        chk({7'h0, serial_out_line}, 8'h01);
        op(0, 8'h40);
        tick(1);
        chk({7'h0, serial_out_line}, 8'h00);
        {edge_restart, mid_restart, low_restart} <= 3'h0;
        op(2, 8'h00);
        op(5, 8'h00);
        tick(4);
        op(4, 8'h00);
        tick(2);
        chk({7'h0, int_enable}, 8'h00);
        chk({5'h0, grant_source}, {5'h0, SRC_NMI});
        op(1, 8'h00);
        tick(1);
        chk(read_mask_data & 8'h08, 8'h08);
        op(1, 8'h00);
        tick(1);
        chk(read_mask_data & 8'h08, 8'h00);
        op(2, 8'h00);
        sys_rst <= 1'b1;
        tick(2);
        sys_rst <= 1'b0;
        op(1, 8'h00);
        tick(1);
        chk(read_mask_data, 8'h07);
        close_out();
    end
    initial begin
        #200000;
        error_cnt++;
        close_out();
    end
endmodule : general_maskable_request_ctrl_bench
